// ==== src/iepc_pkg.sv ====
package iepc_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [7:0] IEPC_EN_ADDR    = 8'hA8;
  localparam logic [7:0] IEPC_PRIH_ADDR  = 8'hB7;
  localparam logic [7:0] IEPC_PRIL_ADDR  = 8'hB8;
  localparam logic [7:0] IEPC_STAT_ADDR  = 8'hC1;
  localparam logic [7:0] IEPC_MASK_ADDR  = 8'hC2;
  localparam logic [7:0] IEPC_ISVC_ADDR  = 8'hC3;

  // ***************************************************************
  // Reset values and field layout
  // ***************************************************************
  localparam logic [7:0] IEPC_EN_RST     = 8'h00;
  localparam logic [6:0] IEPC_PRI_RST    = 7'h00;
  localparam logic [6:0] IEPC_STAT_RST   = 7'h00;
  localparam logic [6:0] IEPC_MASK_RST   = 7'h00;
  localparam logic [3:0] IEPC_ISVC_RST   = 4'h0;
  localparam int         IEPC_GATE_BIT   = 7;
  localparam int         IEPC_NSRC       = 7;
  localparam logic [7:0] IEPC_BYTE_MASK  = 8'hF8;

  // Source index, equal to the polling position (0 polls first)
  localparam logic [2:0] IEPC_SRC_EXT_A  = 3'h0;
  localparam logic [2:0] IEPC_SRC_TMR_A  = 3'h1;
  localparam logic [2:0] IEPC_SRC_EXT_B  = 3'h2;
  localparam logic [2:0] IEPC_SRC_TMR_B  = 3'h3;
  localparam logic [2:0] IEPC_SRC_PWU_A  = 3'h4;
  localparam logic [2:0] IEPC_SRC_PWU_B  = 3'h5;
  localparam logic [2:0] IEPC_SRC_CONV   = 3'h6;

  // ***************************************************************
  // Vector layout
  // ***************************************************************
  localparam logic [15:0] IEPC_VEC_BASE  = 16'h0003;
  localparam int          IEPC_VEC_SHIFT = 3;

  typedef logic [1:0] iepc_level_t;

endpackage

// ==== src/iepc_ctrl.sv ====
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module iepc_ctrl
  import iepc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Byte register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  // Bit register port
  input  wire logic [7:0]  bit_addr_in,
  input  wire logic        bit_wdata_in,
  input  wire logic        bit_wr_in,
  input  wire logic        bit_rd_in,
  output logic             bit_rdata_out,
  // Raw request pulses from peripherals, index is polling position
  input  wire logic [6:0]  src_event_in,
  // Core service handshake
  input  wire logic        core_ack_in,
  input  wire logic        core_reti_in,
  output logic             core_req_out,
  output logic      [2:0]  core_idx_out,
  output logic      [15:0] core_vec_out,
  output var iepc_pkg::iepc_level_t core_level_out,
  // Summary interrupt
  output logic             irq_out
);
  import iepc_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  logic [7:0]  irq_enable_reg;
  logic [6:0]  irq_priority_low_reg;
  logic [6:0]  irq_priority_high_reg;
  logic [6:0]  stat_reg;
  logic [6:0]  mask_reg;
  logic [3:0]  isvc_reg;
  logic        req_reg;
  logic [2:0]  idx_reg;
  iepc_level_t lvl_reg;
  logic [7:0]  rdata_reg;
  logic        bit_rdata_reg;
  logic [15:0] vec_reg;

  // ***************************************************************
  // Byte decode
  // ***************************************************************
  wire         sel_en    = (addr_in == IEPC_EN_ADDR);
  wire         sel_prih  = (addr_in == IEPC_PRIH_ADDR);
  wire         sel_pril  = (addr_in == IEPC_PRIL_ADDR);
  wire         sel_stat  = (addr_in == IEPC_STAT_ADDR);
  wire         sel_mask  = (addr_in == IEPC_MASK_ADDR);
  wire         sel_isvc  = (addr_in == IEPC_ISVC_ADDR);

  // ***************************************************************
  // Bit decode: high priority register sits off the 8-aligned grid
  // ***************************************************************
  wire [7:0]   bit_byte  = bit_addr_in & IEPC_BYTE_MASK;
  wire [2:0]   bit_pos   = bit_addr_in[2:0];
  wire         bsel_en   = (bit_byte == IEPC_EN_ADDR);
  wire         bsel_pril = (bit_byte == IEPC_PRIL_ADDR);

  // ***************************************************************
  // Register next values
  // ***************************************************************
  logic [7:0]  irq_enable_next;
  logic [6:0]  irq_priority_low_next;
  logic [6:0]  irq_priority_high_next;

  always_comb
  begin
    irq_enable_next        = irq_enable_reg;
    irq_priority_low_next  = irq_priority_low_reg;
    irq_priority_high_next = irq_priority_high_reg;
    if (wr_in && sel_en)
      irq_enable_next = wdata_in;
    if (wr_in && sel_pril)
      irq_priority_low_next = wdata_in[6:0];
    if (wr_in && sel_prih)
      irq_priority_high_next = wdata_in[6:0];
    if (bit_wr_in && bsel_en)
      irq_enable_next[bit_pos] = bit_wdata_in;
    // Bit 7 is not stored, so a stray set of it is harmless
    if (bit_wr_in && bsel_pril && (bit_pos != 3'h7))
      irq_priority_low_next[bit_pos] = bit_wdata_in;
  end

  // ***************************************************************
  // Event status: set wins over any clear in the same cycle
  // ***************************************************************
  wire [6:0]   w1c_clr  = (wr_in && sel_stat) ? wdata_in[6:0] : 7'h00;
  wire [7:0]   bit_onehot_idx = 8'h01 << idx_reg;
  // The core acks only a standing request; the ack clears the shown source
  wire [6:0]   ack_clr  = core_ack_in ? 7'(bit_onehot_idx) : 7'h00;
  wire [6:0]   stat_next = (stat_reg & ~(w1c_clr | ack_clr)) | src_event_in;

  // ***************************************************************
  // Gating and arbitration
  // ***************************************************************
  wire         gate_on  = irq_enable_reg[IEPC_GATE_BIT];
  // Bits 6..0 line up with the polling index of each source
  wire [6:0]   src_en   = irq_enable_reg[6:0];
  wire [6:0]   eligible = gate_on ? (stat_reg & src_en) : 7'h00;

  logic        win_found;
  logic [2:0]  win_idx;
  iepc_level_t win_lvl;
  iepc_level_t src_lvl;

  always_comb
  begin
    src_lvl   = 2'h0;
    win_found = 1'b0;
    win_idx   = 3'h0;
    win_lvl   = 2'h0;
    // Descending scan with >= lets the earlier source win a tie
    for (int i = IEPC_NSRC - 1; i >= 0; i--)
    begin
      src_lvl = {irq_priority_high_reg[i], irq_priority_low_reg[i]};
      if (eligible[i] && (!win_found || (src_lvl >= win_lvl)))
      begin
        win_found = 1'b1;
        win_idx   = 3'(i);
        win_lvl   = src_lvl;
      end
    end
  end

  // ***************************************************************
  // Preemption
  // ***************************************************************
  // Highest level now in service; level 3 in service blocks everything
  logic        busy_any;
  iepc_level_t busy_lvl;

  always_comb
  begin
    busy_any = |isvc_reg;
    busy_lvl = 2'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (isvc_reg[l])
        busy_lvl = 2'(l);
    end
  end

  wire         preempt_ok = !busy_any || (win_lvl > busy_lvl);
  wire         req_next   = win_found && preempt_ok;

  // ***************************************************************
  // In-service stack of levels
  // ***************************************************************
  logic [3:0]  isvc_top;

  always_comb
  begin
    isvc_top = 4'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (isvc_reg[l])
        isvc_top = 4'h1 << l;
    end
  end

  // One bit per level suffices, since a level never preempts itself
  wire [3:0]   isvc_set  = core_ack_in ? (4'h1 << lvl_reg) : 4'h0;
  wire [3:0]   isvc_clr  = core_reti_in ? isvc_top : 4'h0;
  wire [3:0]   isvc_next = (isvc_reg & ~isvc_clr) | isvc_set;

  // ***************************************************************
  // Read path
  // ***************************************************************
  logic [7:0]  rd_mux;

  always_comb
  begin
    rd_mux = 8'h00;
    if (sel_en)
      rd_mux = irq_enable_reg;
    else if (sel_pril)
      rd_mux = {1'b0, irq_priority_low_reg};
    else if (sel_prih)
      rd_mux = {1'b0, irq_priority_high_reg};
    else if (sel_stat)
      rd_mux = {1'b0, stat_reg};
    else if (sel_mask)
      rd_mux = {1'b0, mask_reg};
    else if (sel_isvc)
      rd_mux = {4'h0, isvc_reg};
  end

  wire [7:0]   pril_full  = {1'b0, irq_priority_low_reg};
  wire         rd_pril_bit = pril_full[bit_pos];
  // Bit reads of any other byte return zero, so probing is harmless
  wire         bit_rd_mux = bsel_en   ? irq_enable_reg[bit_pos] :
                            bsel_pril ? rd_pril_bit : 1'b0;

  // ***************************************************************
  // Flip-flops
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_enable_reg        <= IEPC_EN_RST;
      irq_priority_low_reg  <= IEPC_PRI_RST;
      irq_priority_high_reg <= IEPC_PRI_RST;
      stat_reg              <= IEPC_STAT_RST;
      mask_reg              <= IEPC_MASK_RST;
      isvc_reg              <= IEPC_ISVC_RST;
    end
    else
    begin
      irq_enable_reg        <= irq_enable_next;
      irq_priority_low_reg  <= irq_priority_low_next;
      irq_priority_high_reg <= irq_priority_high_next;
      stat_reg              <= stat_next;
      if (wr_in && sel_mask)
        mask_reg <= wdata_in[6:0];
      isvc_reg              <= isvc_next;
    end
  end

  // ***************************************************************
  // Winner register
  // ***************************************************************
  // Winner is registered so index, vector and level stay coherent
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      req_reg <= 1'b0;
      idx_reg <= 3'h0;
      lvl_reg <= 2'h0;
      vec_reg <= IEPC_VEC_BASE;
    end
    else
    begin
      // The acked source is withdrawn at once, not one cycle late
      req_reg <= req_next && !core_ack_in;
      idx_reg <= win_idx;
      lvl_reg <= win_lvl;
      vec_reg <= IEPC_VEC_BASE + {10'h000, win_idx, 3'h0};
    end
  end

  // ***************************************************************
  // Read data registers
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rdata_reg     <= 8'h00;
      bit_rdata_reg <= 1'b0;
    end
    else
    begin
      rdata_reg     <= rd_in ? rd_mux : 8'h00;
      bit_rdata_reg <= bit_rd_in ? bit_rd_mux : 1'b0;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign rdata_out      = rdata_reg;
  assign bit_rdata_out  = bit_rdata_reg;
  assign core_req_out   = req_reg;
  assign core_idx_out   = idx_reg;
  assign core_vec_out   = vec_reg;
  assign core_level_out = lvl_reg;
  // Independent of the gate, so software can poll events with interrupts off
  assign irq_out        = |(stat_reg & mask_reg);

endmodule
`default_nettype wire

// ==== tb/iepc_ctrl_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module iepc_chk (
  // Clock, reset and register ports
  input wire logic        clk_in,
  input wire logic        rst_b_in,
  input wire logic [7:0]  addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [7:0]  rdata_out,
  input wire logic [7:0]  bit_addr_in,
  input wire logic        bit_wdata_in,
  input wire logic        bit_wr_in,
  input wire logic        bit_rd_in,
  input wire logic        bit_rdata_out,
  // Sources and core link
  input wire logic [6:0]  src_event_in,
  input wire logic        core_ack_in,
  input wire logic        core_reti_in,
  input wire logic        core_req_out,
  input wire logic [2:0]  core_idx_out,
  input wire logic [15:0] core_vec_out,
  input wire iepc_pkg::iepc_level_t core_level_out,
  input wire logic        irq_out
);
  import iepc_pkg::*;
  logic gate_reg;
  logic lvl3_reg;
  // The gate only opens through a write with bit 7 set
  wire gate_set = (wr_in && addr_in == IEPC_EN_ADDR && wdata_in[7]) ||
    (bit_wr_in && bit_addr_in == IEPC_EN_ADDR + 8'h07 && bit_wdata_in);
  wire lvl3_next = (core_ack_in && core_level_out == 2'h3) || (lvl3_reg && !core_reti_in);
  wire [7:0] bit_byte = bit_addr_in & IEPC_BYTE_MASK;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      gate_reg <= 1'h0;
      lvl3_reg <= 1'h0;
    end
    else
    begin
      gate_reg <= gate_reg | gate_set;
      lvl3_reg <= lvl3_next;
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ****
  // Checks
  // ****
  rd_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not idle");
  vec_map_a: assert property (core_vec_out == 16'h0003 + 16'(core_idx_out) * 16'h0008)
    else $error("vector does not match index");
  vec_end_a: assert property (core_idx_out == IEPC_SRC_CONV |-> core_vec_out == 16'h0033)
    else $error("converter vector wrong");
  ack_drop_a: assert property (core_ack_in |=> !core_req_out)
    else $error("request stands after ack");
  top_level_a: assert property (lvl3_reg |-> !core_req_out)
    else $error("request during top level service");
  gate_closed_a: assert property (!gate_reg |-> !core_req_out)
    else $error("request with gate never opened");
  irq_cause_a: assert property ($rose(irq_out) |-> $past(src_event_in) != 7'h00 || $past(wr_in))
    else $error("interrupt rose without cause");
  bit_unmapped_a: assert property (bit_rd_in && bit_byte != IEPC_EN_ADDR &&
    bit_byte != IEPC_PRIL_ADDR |=> !bit_rdata_out) else $error("bit read outside map");
  prio_msb_a: assert property (rd_in && (addr_in == IEPC_PRIH_ADDR ||
    addr_in == IEPC_PRIL_ADDR) |=> !rdata_out[7]) else $error("priority bit 7 set");
endmodule
`default_nettype wire

// ==== tb/iepc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module iepc_core_model (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  // Service handshake
  input wire logic [3:0] lat_in,
  input wire logic       req_in,
  output logic           ack_out,
  output logic           reti_out,
  output logic [3:0]     depth_out
);
  logic [3:0] wait_reg;
  // Takes only a standing request; retires last-in first while nothing competes
  wire take = req_in && !ack_out && wait_reg >= lat_in;
  wire done = !req_in && !ack_out && depth_out != 4'h0 && wait_reg >= lat_in;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      ack_out   <= 1'h0;
      reti_out  <= 1'h0;
      depth_out <= 4'h0;
      wait_reg  <= 4'h0;
    end
    else
    begin
      ack_out   <= take;
      reti_out  <= done;
      depth_out <= depth_out + 4'(take) - 4'(done);
      wait_reg  <= (take || done) ? 4'h0 : wait_reg + 4'h1;
    end
endmodule
`default_nettype wire

// ==== tb/iepc_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module iepc_ctrl_tb;
  import iepc_pkg::*;
  logic        clk_in = 1'h0, rst_b_in = 1'h0, wr_in = 1'h0, rd_in = 1'h0;
  logic        bit_wr_in = 1'h0, bit_rd_in = 1'h0, bit_wdata_in = 1'h0;
  logic [7:0]  addr_in = 8'h00, wdata_in = 8'h00, bit_addr_in = 8'h00, rdata_out, rd_q;
  logic [6:0]  src_event_in = 7'h00, hi, lo, m;
  logic [3:0]  lat_in = 4'h2, depth;
  logic        core_ack_in, core_reti_in, core_req_out, bit_rdata_out, irq_out, brd_q;
  logic [2:0]  core_idx_out;
  logic [15:0] core_vec_out;
  logic [4:0]  w;
  iepc_level_t core_level_out;
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  logic [7:0]  regs [6] = '{IEPC_EN_ADDR, IEPC_PRIH_ADDR, IEPC_PRIL_ADDR, IEPC_STAT_ADDR,
                           IEPC_MASK_ADDR, IEPC_ISVC_ADDR};
  always #4 clk_in = ~clk_in;
  iepc_ctrl dut (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .bit_addr_in, .bit_wdata_in, .bit_wr_in, .bit_rd_in, .bit_rdata_out, .src_event_in,
    .core_ack_in, .core_reti_in, .core_req_out, .core_idx_out, .core_vec_out,
    .core_level_out, .irq_out);
  iepc_core_model partner (.clk_in, .rst_b_in, .lat_in, .req_in(core_req_out),
    .ack_out(core_ack_in), .reti_out(core_reti_in), .depth_out(depth));
  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One access on the byte port or the bit port; a spare cycle keeps strobes apart
  task automatic acc(input logic bp, input logic wr, input logic [7:0] a, input logic [7:0] d);
    addr_in      <= a;
    bit_addr_in  <= a;
    wdata_in     <= d;
    bit_wdata_in <= d[0];
    wr_in        <= !bp && wr;
    rd_in        <= !bp && !wr;
    bit_wr_in    <= bp && wr;
    bit_rd_in    <= bp && !wr;
    @(posedge clk_in);
    {wr_in, rd_in, bit_wr_in, bit_rd_in} <= 4'h0;
    #1 {rd_q, brd_q} = {rdata_out, bit_rdata_out};
    @(posedge clk_in);
  endtask
  task automatic ev(input logic [6:0] s);
    src_event_in <= s;
    @(posedge clk_in);
    src_event_in <= 7'h00;
    @(posedge clk_in);
    #1;
  endtask
  task automatic drain();
    int q = 0;
    while (q < 4)
    begin
      @(posedge clk_in);
      q = (core_req_out || depth != 4'h0) ? 0 : q + 1;
    end
  endtask
  // Highest level wins, lower polling index wins a tie
  function automatic logic [4:0] win(input logic [6:0] s);
    logic [4:0] b = 5'h00;
    for (int i = 6; i >= 0; i--)
      if (s[i] && {hi[i], lo[i]} >= b[4:3])
        b = {hi[i], lo[i], 3'(i)};
    return b;
  endfunction
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end
  initial
  begin
    void'($urandom(21303));
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'h1;
    @(posedge clk_in);
    foreach (regs[i])
    begin
      acc(0, 0, regs[i], 8'h00);
      chk("reset value", 8'h00, rd_q);
    end
    repeat (8)
    begin
      m = 7'($urandom);
      acc(0, 1, IEPC_PRIH_ADDR, {1'h0, m});
      acc(0, 1, IEPC_PRIL_ADDR, {1'h0, ~m});
      acc(0, 1, 8'h00, 8'hFF);
      acc(0, 0, IEPC_PRIH_ADDR, 8'h00);
      chk("prio high", {1'h0, m}, rd_q);
      acc(0, 0, IEPC_PRIL_ADDR, 8'h00);
      chk("prio low", {1'h0, ~m}, rd_q);
      acc(0, 0, 8'h00, 8'h00);
      chk("unmapped", 8'h00, rd_q);
    end
    for (int i = 0; i < 8; i++)
    begin
      m[0] = 1'($urandom);
      acc(1, 1, IEPC_EN_ADDR + 8'(i), {7'h00, m[0]});
      acc(1, 0, IEPC_EN_ADDR + 8'(i), 8'h00);
      chk("enable bit", m[0], brd_q);
    end
    acc(0, 1, IEPC_PRIL_ADDR, 8'h00);
    acc(1, 1, IEPC_PRIL_ADDR + 8'h03, 8'h01);
    acc(1, 0, IEPC_PRIH_ADDR, 8'h00);
    chk("bit high prio", 0, brd_q);
    acc(0, 0, IEPC_PRIL_ADDR, 8'h00);
    chk("prio low bit", 8'h08, rd_q);
    for (int i = 0; i < 7; i++)
    begin
      acc(0, 1, IEPC_EN_ADDR, 8'h7F);
      ev(7'h01 << i);
      chk("gate closed", 0, core_req_out);
      acc(0, 1, IEPC_EN_ADDR, ~(8'h01 << i));
      #1 chk("own bit clear", 0, core_req_out);
      acc(0, 1, IEPC_EN_ADDR, 8'h80 | (8'h01 << i));
      #1 chk("req", 1, core_req_out);
      chk("idx", 16'(i), core_idx_out);
      chk("vec", 16'h0003 + 16'(i * 8), core_vec_out);
      drain();
    end
    acc(0, 1, IEPC_EN_ADDR, 8'hFF);
    for (int k = 0; k < 20; k++)
    begin
      {hi, lo, m} = (k == 0) ? {14'h0000, 7'h7F} : 21'($urandom);
      m = (m == 7'h00) ? 7'h60 : m;
      acc(0, 1, IEPC_PRIH_ADDR, {1'h0, hi});
      acc(0, 1, IEPC_PRIL_ADDR, {1'h0, lo});
      ev(m);
      w = win(m);
      chk("win idx", w[2:0], core_idx_out);
      chk("win level", w[4:3], core_level_out);
      drain();
    end
    acc(0, 1, IEPC_PRIH_ADDR, 8'h40);
    acc(0, 1, IEPC_PRIL_ADDR, 8'h43);
    lat_in <= 4'hF;
    ev(7'h01);
    for (int t = 0; t < 40 && depth == 4'h0; t++)
      @(posedge clk_in);
    ev(7'h02);
    chk("equal level held", 0, core_req_out);
    ev(7'h40);
    chk("preempt req", 1, core_req_out);
    chk("preempt idx", 6, core_idx_out);
    drain();
    acc(0, 1, IEPC_EN_ADDR, 8'h00);
    acc(0, 1, IEPC_MASK_ADDR, 8'h08);
    ev(7'h18);
    chk("irq unmasked", 1, irq_out);
    acc(0, 0, IEPC_STAT_ADDR, 8'h00);
    chk("status", 8'h18, rd_q);
    acc(0, 1, IEPC_MASK_ADDR, 8'h00);
    chk("irq masked", 0, irq_out);
    acc(0, 1, IEPC_MASK_ADDR, 8'h7F);
    acc(0, 1, IEPC_STAT_ADDR, 8'h18);
    chk("irq cleared", 0, irq_out);
    results();
  end
endmodule
bind iepc_ctrl iepc_chk u_chk (.clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .bit_addr_in, .bit_wdata_in, .bit_wr_in, .bit_rd_in, .bit_rdata_out,
  .src_event_in, .core_ack_in, .core_reti_in, .core_req_out, .core_idx_out,
  .core_vec_out, .core_level_out, .irq_out);
`default_nettype wire
